// [hdl/ext_irq_pkg.sv]
// How it works
// - Software trap is taken regardless of mask; vector 0x0ffc/0x0ffd.
// - Pending hardware request is serviced before the software trap.
// - Interrupt mask blocks every hardware request; clearing it releases them.
// - Edge mode: pin falling edge, or port rising edge, sets latch.
// - Level mode: pin low or port high also asserts the request.
// - External flag starts a sequence only with main enable; vector 0x0ffa.
// - Vector fetch clears external latch only when second enable is clear.
// - Main acknowledge clears external latch; levels must also be inactive.
// - Active flag with main enable keeps re-entering the external sequence.
// - Enabled dedicated pin falling edge sets second latch; shared vector.
// - Second flag is cleared only by its acknowledge or reset.
// - Second flag with its enable keeps re-entering the sequence.
// - Control/status register at index 0x0a; unused bits read zero.
// - Reset clears both flags and second enable, sets main enable.
// - Acknowledge bits read zero; writing zero leaves latches unchanged.
// - Writes to flag positions do not change the flags.
// - Stop or wait sets main enable, leaves second enable alone.
// - Port pins are ORed with the pin and gated by main enable.
// - Branch-on-pin tests only the interrupt pin, not the OR result.
// - Port pins raise requests whatever their direction.
// - Timer overflow and real-time share vector 0x0ff8; masked by mask.
// - Higher vector wins among hardware requests (0x0ffa over 0x0ff8); the software trap waits for any hardware request.
// - Finish instruction, stack, set mask, then fetch vector.
package ext_irq_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0]  CTRL_STATUS_INDEX = 8'h0a;
  localparam logic [11:0] CTRL_STATUS_ADDR  = {2'h0, CTRL_STATUS_INDEX, 2'h0};
  localparam int          BIT_MAIN_EN       = 7;
  localparam int          BIT_SECOND_EN     = 6;
  localparam int          BIT_MAIN_ACK      = 5;
  localparam int          BIT_SECOND_ACK    = 4;
  localparam int          BIT_MAIN_FLAG     = 3;
  localparam int          BIT_SECOND_FLAG   = 2;
  localparam logic        MAIN_EN_RESET     = 1'h1;
  localparam logic        SECOND_EN_RESET   = 1'h0;

  // ************************************************************
  // Vector addresses
  // ************************************************************
  localparam logic [15:0] VEC_SOFTWARE = 16'h0ffc;
  localparam logic [15:0] VEC_EXTERNAL = 16'h0ffa;
  localparam logic [15:0] VEC_TIMER    = 16'h0ff8;

  // ************************************************************
  // Interrupt sequence states
  // ************************************************************
  typedef enum logic [3:0] {
    SEQ_IDLE  = 4'h1,
    SEQ_STACK = 4'h2,
    SEQ_MASK  = 4'h4,
    SEQ_FETCH = 4'h8
  } seq_state_t;

endpackage

// [hdl/external_interrupt_logic.sv]
`timescale 1ns/100ps
module external_interrupt_logic
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Mask options
  input  wire logic        port_pin_option,
  input  wire logic        level_sense_option,
  // External pins
  input  wire logic        irq_pin_n,
  input  wire logic [3:0]  low_port_pins,
  input  wire logic        dedicated_edge_pin,
  // Timer requests
  input  wire logic        timer_overflow_req,
  input  wire logic        timer_realtime_req,
  // Processor core
  input  wire logic        interrupt_mask,
  input  wire logic        insn_done,
  input  wire logic        software_trap,
  input  wire logic        stack_done,
  input  wire logic        vector_fetched,
  input  wire logic        stop_or_wait,
  output logic             stack_req,
  output logic             set_mask,
  output logic             vector_valid,
  output logic      [15:0] vector_addr,
  output logic             hw_request,
  output logic             pin_level
);

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic       irq_s2;
  logic       irq_prev;
  logic [3:0] port_s2;
  logic [3:0] port_prev;
  logic       ded_s2;
  logic       ded_prev;

  pin_sync
  #(
    .WIDTH (1),
    .IDLE  (1'h1)
  )
  i_irq_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (irq_pin_n),
    .synced  (irq_s2),
    .delayed (irq_prev)
  );

  pin_sync
  #(
    .WIDTH (4),
    .IDLE  (4'h0)
  )
  i_port_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (low_port_pins),
    .synced  (port_s2),
    .delayed (port_prev)
  );

  pin_sync
  #(
    .WIDTH (1),
    .IDLE  (1'h1)
  )
  i_ded_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (dedicated_edge_pin),
    .synced  (ded_s2),
    .delayed (ded_prev)
  );

  wire irq_fall  = irq_prev & ~irq_s2;
  wire port_rise = port_pin_option & (|(port_s2 & ~port_prev));
  wire ded_fall  = ded_prev & ~ded_s2;

  // ************************************************************
  // Register access decode
  // ************************************************************
  logic                    main_en;
  logic                    second_en;
  logic                    main_latch;
  logic                    second_flag;
  ext_irq_pkg::seq_state_t state;

  wire access    = psel & penable;
  wire hit       = paddr == ext_irq_pkg::CTRL_STATUS_ADDR;
  wire wr_stb    = access & pready & pwrite & hit;
  wire main_ack  = wr_stb & pwdata[ext_irq_pkg::BIT_MAIN_ACK];
  wire sec_ack   = wr_stb & pwdata[ext_irq_pkg::BIT_SECOND_ACK];

  // ************************************************************
  // Request flags
  // ************************************************************
  wire edge_set   = irq_fall | port_rise;
  wire level_on   = level_sense_option
                    & (~irq_s2 | (port_pin_option & (|port_s2)));
  wire main_flag  = main_latch | level_on;
  wire ext_vec    = vector_fetched & (state == ext_irq_pkg::SEQ_FETCH)
                    & (vector_addr == ext_irq_pkg::VEC_EXTERNAL);
  wire vec_clear  = ext_vec & ~second_en;
  wire ext_req    = (main_flag & main_en) | (second_flag & second_en);
  wire timer_req  = timer_overflow_req | timer_realtime_req;
  wire any_hw     = (ext_req | timer_req) & ~interrupt_mask;
  wire main_clear = main_ack | vec_clear;
  wire second_set = ded_fall & second_en;

  request_latch i_main_latch
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_stb   (edge_set),
    .clear_stb (main_clear),
    .flag      (main_latch)
  );

  request_latch i_second_latch
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_stb   (second_set),
    .clear_stb (sec_ack),
    .flag      (second_flag)
  );

  // ************************************************************
  // Enable bits
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_en   <= ext_irq_pkg::MAIN_EN_RESET;
      second_en <= ext_irq_pkg::SECOND_EN_RESET;
    end
    else
    begin
      if (stop_or_wait)
        main_en <= 1'h1;
      else if (wr_stb)
        main_en <= pwdata[ext_irq_pkg::BIT_MAIN_EN];
      if (wr_stb)
        second_en <= pwdata[ext_irq_pkg::BIT_SECOND_EN];
    end
  end

  // ************************************************************
  // Read data and bus answer
  // ************************************************************
  logic [31:0] read_word;

  always_comb
  begin
    read_word = 32'h0;
    read_word[ext_irq_pkg::BIT_MAIN_EN]     = main_en;
    read_word[ext_irq_pkg::BIT_SECOND_EN]   = second_en;
    read_word[ext_irq_pkg::BIT_MAIN_FLAG]   = main_flag;
    read_word[ext_irq_pkg::BIT_SECOND_FLAG] = second_flag;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~hit;
      if (access & ~pready & ~pwrite & hit)
        prdata <= read_word;
      else
        prdata <= 32'h0;
    end
  end

  // ************************************************************
  // Interrupt sequence
  // ************************************************************
  logic                    is_swi;
  ext_irq_pkg::seq_state_t next_state;
  logic [15:0]             next_vector;

  // External request has the higher vector, so it wins over the timer
  wire [15:0] hw_vector = ext_req ? ext_irq_pkg::VEC_EXTERNAL
                                  : ext_irq_pkg::VEC_TIMER;

  always_comb
  begin
    next_state  = state;
    next_vector = vector_addr;
    case (state)
      ext_irq_pkg::SEQ_IDLE:
        if (insn_done & (any_hw | software_trap))
          next_state = ext_irq_pkg::SEQ_STACK;
      ext_irq_pkg::SEQ_STACK:
        if (stack_done)
          next_state = ext_irq_pkg::SEQ_MASK;
      ext_irq_pkg::SEQ_MASK:
      begin
        next_state = ext_irq_pkg::SEQ_FETCH;
        if (is_swi)
          next_vector = ext_irq_pkg::VEC_SOFTWARE;
        else
          next_vector = hw_vector;
      end
      ext_irq_pkg::SEQ_FETCH:
        if (vector_fetched)
          next_state = ext_irq_pkg::SEQ_IDLE;
      default:
        next_state = ext_irq_pkg::SEQ_IDLE;
    endcase
  end

  wire in_idle     = state == ext_irq_pkg::SEQ_IDLE;
  wire enter_stack = next_state == ext_irq_pkg::SEQ_STACK;
  wire enter_mask  = next_state == ext_irq_pkg::SEQ_MASK;
  wire enter_fetch = next_state == ext_irq_pkg::SEQ_FETCH;
  // Hardware goes first; the core offers the trap again later
  wire trap_only   = ~any_hw & software_trap;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= ext_irq_pkg::SEQ_IDLE;
      is_swi       <= 1'h0;
      vector_addr  <= 16'h0;
      stack_req    <= 1'h0;
      set_mask     <= 1'h0;
      vector_valid <= 1'h0;
    end
    else
    begin
      state        <= next_state;
      vector_addr  <= next_vector;
      stack_req    <= enter_stack;
      set_mask     <= enter_mask;
      vector_valid <= enter_fetch;
      if (in_idle)
        is_swi <= trap_only;
    end
  end

  // ************************************************************
  // Core-facing status
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_request <= 1'h0;
      pin_level  <= 1'h1;
    end
    else
    begin
      hw_request <= any_hw;
      pin_level  <= irq_s2;
    end
  end

endmodule

// ************************************************************
// Two-stage pin synchroniser with one stage of history
// ************************************************************
module pin_sync
#(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE  = '0
)
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pin and its synchronised copies
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] synced,
  output logic      [WIDTH-1:0] delayed
);

  logic [WIDTH-1:0] stage1;

  // Reset to the pin's idle level so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1  <= IDLE;
      synced  <= IDLE;
      delayed <= IDLE;
    end
    else
    begin
      stage1  <= pin;
      synced  <= stage1;
      delayed <= synced;
    end
  end

endmodule

// ************************************************************
// Request latch: a set in the same cycle as a clear wins
// ************************************************************
module request_latch
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Set and clear strobes
  input  wire logic set_stb,
  input  wire logic clear_stb,
  // Latched request
  output logic      flag
);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag <= 1'h0;
    else if (set_stb)
      flag <= 1'h1;
    else if (clear_stb)
      flag <= 1'h0;
  end

endmodule

// [testbench/core_model.sv]
`timescale 1ns/100ps
module core_model
#(
  parameter int STALL = 2
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Sequence handshake
  input  wire logic        stack_req,
  input  wire logic        vector_valid,
  input  wire logic [15:0] vector_addr,
  output logic             stack_done,
  output logic             vector_fetched,
  output logic      [15:0] last_vec
);
  int cnt;
  // Stack first, fetch only once a vector is offered
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt <= 0;
      stack_done <= 1'b0;
      vector_fetched <= 1'b0;
      last_vec <= 16'h0;
    end
    else
    begin
      cnt <= stack_req && !stack_done ? cnt + 1 : 0;
      stack_done <= stack_req && !stack_done && cnt >= STALL;
      vector_fetched <= vector_valid && !vector_fetched;
      if (vector_valid && !vector_fetched)
        last_vec <= vector_addr;
    end
endmodule

// [testbench/ext_irq_checker_sva.sv]
`timescale 1ns/100ps
module ext_irq_checker
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Core and pins
  input wire logic        irq_pin_n,
  input wire logic        interrupt_mask,
  input wire logic        insn_done,
  input wire logic        software_trap,
  input wire logic        stack_done,
  input wire logic        vector_fetched,
  input wire logic        stack_req,
  input wire logic        set_mask,
  input wire logic        vector_valid,
  input wire logic [15:0] vector_addr,
  input wire logic        hw_request,
  input wire logic        pin_level
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire idle = !stack_req && !set_mask && !vector_valid;
  sequence s_stacked;
    stack_req && stack_done;
  endsequence
  sequence s_mask_vec;
    !stack_req && set_mask ##1 !set_mask && vector_valid;
  endsequence

  AST_PREADY_WAIT: assert property (psel && !penable ##1 psel && penable
    |-> !pready ##1 pready) else $error("pready timing wrong");
  AST_READ_ZERO: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h0 && prdata[5:4] == 2'h0 && prdata[1:0] == 2'h0)
    else $error("unused or ack bits read nonzero");
  AST_UNMAPPED: assert property (psel && penable && pready &&
    paddr != ext_irq_pkg::CTRL_STATUS_ADDR |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MASK_BLOCKS: assert property (interrupt_mask [*2] |-> !hw_request)
    else $error("request pending while masked");
  AST_TRAP: assert property (idle && insn_done && software_trap |=> stack_req)
    else $error("trap not taken");
  AST_HW_TAKEN: assert property (idle && insn_done && hw_request &&
    !interrupt_mask |=> stack_req) else $error("request not taken");
  AST_SEQ: assert property (s_stacked |=> s_mask_vec)
    else $error("sequence steps out of order");
  AST_VEC_HOLD: assert property (vector_valid && !vector_fetched |=>
    vector_valid && $stable(vector_addr)) else $error("vector dropped");
  AST_VEC_LEGAL: assert property (vector_valid |-> vector_addr inside
    {16'h0ffc, 16'h0ffa, 16'h0ff8}) else $error("vector address illegal");
  AST_PIN: assert property ($stable(irq_pin_n) [*4] |->
    pin_level == irq_pin_n) else $error("pin level wrong");
endmodule
bind external_interrupt_logic ext_irq_checker i_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .irq_pin_n,
  .interrupt_mask, .insn_done, .software_trap, .stack_done, .vector_fetched,
  .stack_req, .set_mask, .vector_valid, .vector_addr, .hw_request, .pin_level);

// [testbench/tb_external_interrupt_logic.sv]
`timescale 1ns/100ps
module tb_external_interrupt_logic;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        port_pin_option, level_sense_option, irq_pin_n, set_mask;
  logic        dedicated_edge_pin, timer_overflow_req, timer_realtime_req;
  logic        interrupt_mask, insn_done, software_trap, stack_done;
  logic        vector_fetched, stop_or_wait, stack_req, vector_valid;
  logic        hw_request, pin_level;
  logic [3:0]  low_port_pins;
  logic [7:0]  rd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] vector_addr, last_vec;
  int          n_fail, cmp_count;
  localparam logic [11:0] A = ext_irq_pkg::CTRL_STATUS_ADDR;

  external_interrupt_logic i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .port_pin_option,
    .level_sense_option, .irq_pin_n, .low_port_pins, .dedicated_edge_pin,
    .timer_overflow_req, .timer_realtime_req, .interrupt_mask, .insn_done,
    .software_trap, .stack_done, .vector_fetched, .stop_or_wait, .stack_req,
    .set_mask, .vector_valid, .vector_addr, .hw_request, .pin_level);
  core_model i_core (.pclk, .presetn, .stack_req, .vector_valid,
    .vector_addr, .stack_done, .vector_fetched, .last_vec);

  always #2.5 pclk = ~pclk;

  // ********
  // Tasks
  // ********
  task automatic chk(input string s, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] e);
    apb(1'b0, A, 8'h0);
    chk("reg", {8'h0, e}, {8'h0, rd});
  endtask
  task automatic run_seq(input logic trap, input logic [15:0] v);
    int t;
    @(posedge pclk);
    insn_done <= 1'b1;
    software_trap <= trap;
    @(posedge pclk);
    insn_done <= 1'b0;
    software_trap <= 1'b0;
    for (t = 0; t < 40 && vector_fetched !== 1'b1; t++)
      @(posedge pclk);
    chk("fetched", 16'h1, {15'h0, vector_fetched});
    repeat (2) @(posedge pclk);
    chk("vector", v, last_vec);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    rdchk(8'h80);
    apb(1'b1, A, 8'h7f);
    rdchk(8'h40);
    apb(1'b0, 12'h02c, 8'h0);
    chk("pslverr", 16'h1, {15'h0, err});
    stop_or_wait <= 1'b1;
    @(posedge pclk);
    stop_or_wait <= 1'b0;
    rdchk(8'hc0);
    apb(1'b1, A, 8'h80);
    $display("done t_regs");
  endtask
  task automatic t_ext;
    irq_pin_n <= 1'b0;
    repeat (8) @(posedge pclk);
    rdchk(8'h88);
    chk("pin", 16'h0, {15'h0, pin_level});
    run_seq(1'b1, ext_irq_pkg::VEC_SOFTWARE);
    interrupt_mask <= 1'b0;
    run_seq(1'b1, ext_irq_pkg::VEC_EXTERNAL);
    rdchk(8'h80);
    irq_pin_n <= 1'b1;
    low_port_pins <= 4'h8;
    repeat (8) @(posedge pclk);
    rdchk(8'h88);
    chk("pin", 16'h1, {15'h0, pin_level});
    apb(1'b1, A, 8'ha0);
    rdchk(8'h80);
    low_port_pins <= 4'h0;
    timer_overflow_req <= 1'b1;
    run_seq(1'b0, ext_irq_pkg::VEC_TIMER);
    timer_overflow_req <= 1'b0;
    $display("done t_ext");
  endtask
  task automatic t_second;
    apb(1'b1, A, 8'hc0);
    dedicated_edge_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rdchk(8'hc4);
    run_seq(1'b0, ext_irq_pkg::VEC_EXTERNAL);
    rdchk(8'hc4);
    irq_pin_n <= 1'b0;
    repeat (8) @(posedge pclk);
    run_seq(1'b0, ext_irq_pkg::VEC_EXTERNAL);
    rdchk(8'hcc);
    chk("hw_request", 16'h1, {15'h0, hw_request});
    apb(1'b1, A, 8'hf0);
    rdchk(8'hc0);
    $display("done t_second");
  endtask
  task automatic t_level;
    level_sense_option <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(8'hc8);
    apb(1'b1, A, 8'he0);
    rdchk(8'hc8);
    irq_pin_n <= 1'b1;
    port_pin_option <= 1'b0;
    low_port_pins <= 4'h1;
    repeat (8) @(posedge pclk);
    rdchk(8'hc0);
    port_pin_option <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(8'hc8);
    low_port_pins <= 4'h0;
    level_sense_option <= 1'b0;
    $display("done t_level");
  endtask
  task automatic t_reset;
    irq_pin_n <= 1'b0;
    dedicated_edge_pin <= 1'b1;
    @(posedge pclk);
    dedicated_edge_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rdchk(8'hcc);
    irq_pin_n <= 1'b1;
    dedicated_edge_pin <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(8'h80);
    $display("done t_reset");
  endtask

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, insn_done} = 6'h0;
    {software_trap, stop_or_wait, timer_overflow_req} = 3'h0;
    {level_sense_option, timer_realtime_req} = 2'h0;
    {irq_pin_n, dedicated_edge_pin, interrupt_mask, port_pin_option} = 4'hf;
    paddr = 12'h0;
    pwdata = 32'h0;
    low_port_pins = 4'h0;
    n_fail = 0;
    cmp_count = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_ext;
    t_second;
    t_level;
    t_reset;
    report_and_stop;
  end
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    report_and_stop;
  end
endmodule
